// *** rtl/sfs_seq.sv ***
// Erase and program sequencer behind the two-wire serial programming port.
// Assumes serial pins are asynchronous to i_mclk and that the flash array
// acts on the erase, program and panel-enable levels driven from here.
`timescale 1ns/1ps
`default_nettype none
`include "sfs_cfg.svh"

module sfs_fifo #(
   parameter int W = 20,
   parameter int D = 32
) (
   input  wire logic         i_mclk,  // Clock.
   input  wire logic         i_rst,   // Synchronous reset.
   input  wire logic         i_valid, // Writer offers a word.
   output logic              o_ready, // Room for a word.
   input  wire logic [W-1:0] i_data,  // Word written.
   output logic              o_valid, // Head word available.
   input  wire logic         i_ready, // Reader takes the head word.
   output logic [W-1:0]      o_data   // Head word.
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         cnt;
   } fifo_state_type;
   fifo_state_type q;
   fifo_state_type d;
   logic           push;
   logic           pop;

   // Pointers wrap by overflow, so the depth must be a power of two.
   always_comb
   begin
      d = q;
      push = i_valid && o_ready;
      pop = o_valid && i_ready;
      if (push)
      begin
         d.mem[q.wp] = i_data;
         d.wp = q.wp + 1'b1;
      end
      if (pop)
      begin
         d.rp = q.rp + 1'b1;
      end
      d.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   // Flags are honest: full and empty come from the stored count.
   assign o_ready = (q.cnt != D[AW:0]);
   assign o_valid = (q.cnt != '0);
   assign o_data  = q.mem[q.rp];

   // Register the whole state.
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end
endmodule : sfs_fifo

module sfs_seq #(
   parameter int unsigned ERASE_CYC = `SFS_P11_CYC, // Self-timed erase length in cycles.
   parameter int          FIFO_D    = 32             // Instruction queue depth.
) (
   input  wire logic                i_mclk,         // 100 MHz clock.
   input  wire logic                i_rst,          // Synchronous reset, active high.
   input  wire logic                i_pgc,          // prog_serial_clock pin.
   input  wire logic                i_pgd,          // prog_serial_data pin input.
   input  wire sfs_pkg::region_type i_prot_set,     // Protection set strobes, same clock.
   output logic                     o_pgd_out,      // Serial data output level.
   output logic                     o_pgd_oe,       // Serial data output enable.
   output logic                     o_erase_busy,   // Bulk erase running.
   output sfs_pkg::region_type      o_erase_mask,   // Regions being bulk erased.
   output sfs_pkg::region_type      o_prot,         // Protection state per region.
   output logic                     o_prog_on,      // Panel programming active.
   output logic                     o_row_erase_on, // Row erase active on the enabled panels.
   output logic [7:0]               o_panel_en,     // Panels enabled for the operation.
   output logic [12:0]              o_offset,       // In-panel byte offset.
   output sfs_pkg::wbuf_type        o_wbuf,         // Write buffers of all panels.
   output logic [7:0]               o_panel_ctrl,   // panel_write_control contents.
   output logic                     o_overflow      // Instruction lost to a full queue.
);
   import sfs_pkg::*;

   seq_state_type q;
   seq_state_type d;
   logic          rise;
   logic          fall;
   logic          f_ready;
   logic          f_valid;
   logic [19:0]   f_word;
   logic          pop;
   logic [3:0]    cmd;
   logic [15:0]   pl;
   logic [2:0]    panel;

   // Decode an erase option into regions; an unknown code gives no region.
   function automatic region_type erase_decode(input logic [7:0] c);
      region_type m;
      m = '0;
      if (c == `SFS_ER_CHIP)
      begin
         m = '1;
      end
      else if (c == `SFS_ER_DATA)
      begin
         m[1] = 1'b1;
      end
      else if (c == `SFS_ER_BOOT)
      begin
         m[0] = 1'b1;
      end
      else if (c >= `SFS_ER_BLK1 && c <= `SFS_ER_BLK8)
      begin
         // Widened before the add so blocks 7 and 8 do not wrap onto boot and data.
         m[{1'b0, c[2:0]} + `SFS_BLK_BASE] = 1'b1;
      end
      return m;
   endfunction : erase_decode

   // Instructions queue here so a long erase does not drop decoded words.
   sfs_fifo #(.W(20), .D(FIFO_D)) u_fifo (
      .i_mclk  (i_mclk),
      .i_rst   (i_rst),
      .i_valid (q.push_v),
      .o_ready (f_ready),
      .i_data  (q.push_w),
      .o_valid (f_valid),
      .i_ready (!q.ebusy),
      .o_data  (f_word)
   );

   // Edges come from the second and third stages only.
   assign rise  = q.pgc_s[1] && !q.pgc_s[2];
   assign fall  = !q.pgc_s[1] && q.pgc_s[2];
   assign pop   = f_valid && !q.ebusy;
   assign cmd   = f_word[3:0];
   assign pl    = f_word[19:4];
   assign panel = q.tp[15:13];

   // Whole next-state logic: receiver, executor, erase timer, program window.
   always_comb
   begin
      d = q;
      d.pgc_s = {q.pgc_s[1:0], i_pgc};
      d.pgd_s = {q.pgd_s[0], i_pgd};
      d.push_v = 1'b0;
      // Shift on the falling clock, LSb first; suspended while erasing.
      if (fall && !q.ebusy)
      begin
         d.shift = {q.pgd_s[1], q.shift[19:1]};
         if (q.bitcnt == `SFS_LAST_BIT)
         begin
            d.bitcnt = '0;
            d.push_v = 1'b1;
            d.push_w = d.shift;
         end
         else
         begin
            d.bitcnt = q.bitcnt + 5'h01;
         end
         // Erase begins at the 4th fall of a NOP after a valid option.
         if (q.bitcnt == `SFS_CMD_LAST && q.erase_arm && d.shift[19:16] == `SFS_CMD_CORE)
         begin
            d.ebusy = 1'b1;
            d.ecnt = ERASE_CYC - 1;
            d.emask = erase_decode(q.eopt);
            d.prot = q.prot & ~erase_decode(q.eopt);
            d.erase_arm = 1'b0;
         end
      end
      if (q.push_v && !f_ready)
      begin
         d.ovf = 1'b1;
      end
      // Self-timed erase count-down.
      if (q.ebusy)
      begin
         if (q.ecnt == '0)
         begin
            d.ebusy = 1'b0;
            d.emask = '0;
         end
         else
         begin
            d.ecnt = q.ecnt - 32'h1;
         end
      end
      // Program or row erase runs while the 4th clock of the NOP is high.
      if (rise && q.bitcnt == `SFS_CMD_LAST && q.prog_arm && !q.ebusy)
      begin
         d.prog_on = !q.row_mode;
         d.row_on = q.row_mode;
         d.offset = {q.tp[12:3], 3'h0};
         if (q.ctrl[`SFS_MULTI_BIT])
         begin
            d.pen = `SFS_ALL_PANELS;
         end
         else
         begin
            d.pen = 8'h01 << panel;
         end
      end
      if (fall && (q.prog_on || q.row_on))
      begin
         d.prog_on = 1'b0;
         d.row_on = 1'b0;
         d.pen = '0;
         d.prog_arm = 1'b0;
      end
      // Executor: one queued instruction per cycle.
      if (pop)
      begin
         case (cmd)
            `SFS_CMD_CORE:
            begin
               if (pl[15:8] == `SFS_OP_MOVLW)
               begin
                  d.wreg = pl[7:0];
               end
               else if (pl[15:8] == `SFS_OP_MOVWF || pl[15:8] == `SFS_OP_CLRF)
               begin
                  if (pl[7:0] == `SFS_F_TPU)
                  begin
                     d.tp[21:16] = (pl[15:8] == `SFS_OP_MOVWF) ? q.wreg[5:0] : 6'h00;
                  end
                  else if (pl[7:0] == `SFS_F_TPH)
                  begin
                     d.tp[15:8] = (pl[15:8] == `SFS_OP_MOVWF) ? q.wreg : 8'h00;
                  end
                  else if (pl[7:0] == `SFS_F_TPL)
                  begin
                     d.tp[7:0] = (pl[15:8] == `SFS_OP_MOVWF) ? q.wreg : 8'h00;
                  end
               end
               else if (pl[7:0] == `SFS_F_MCR && pl[15:12] == `SFS_OP_BSF)
               begin
                  d.mcr[pl[11:9]] = 1'b1;
               end
               else if (pl[7:0] == `SFS_F_MCR && pl[15:12] == `SFS_OP_BCF)
               begin
                  d.mcr[pl[11:9]] = 1'b0;
               end
            end
            `SFS_CMD_TW, `SFS_CMD_TWPI, `SFS_CMD_TWSP:
            begin
               if (q.mcr[`SFS_MCR_CFG])
               begin
                  if (q.tp == `SFS_OPT_ADDR)
                  begin
                     d.eopt = pl[7:0];
                     d.erase_arm = (erase_decode(pl[7:0]) != '0);
                  end
                  else if (q.tp == `SFS_CTRL_ADDR)
                  begin
                     d.ctrl = pl[7:0];
                  end
               end
               else
               begin
                  d.wbuf[panel][q.tp[2:1]] = pl;
               end
               if (cmd == `SFS_CMD_TWPI)
               begin
                  d.tp = q.tp + `SFS_TP_INC;
               end
               if (cmd == `SFS_CMD_TWSP)
               begin
                  d.prog_arm = 1'b1;
                  d.row_mode = q.mcr[`SFS_MCR_FREE];
               end
            end
            default:
            begin
               d.wreg = q.wreg;
            end
         endcase
      end
      // External set strobes win over a same-cycle erase clear.
      d.prot = d.prot | i_prot_set;
   end

   // Register the whole state.
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   // Outputs are flop fields, the data pin drive tied low; read-back of the data pin is not served.
   assign o_pgd_out      = 1'b0;
   assign o_pgd_oe       = 1'b0;
   assign o_erase_busy   = q.ebusy;
   assign o_erase_mask   = q.emask;
   assign o_prot         = q.prot;
   assign o_prog_on      = q.prog_on;
   assign o_row_erase_on = q.row_on;
   assign o_panel_en     = q.pen;
   assign o_offset       = q.offset;
   assign o_wbuf         = q.wbuf;
   assign o_panel_ctrl   = q.ctrl;
   assign o_overflow     = q.ovf;

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);

   erase_hold_a: assert property ($rose(o_erase_busy) |-> o_erase_busy[*8])
      else $error("erase ended too early");
   erase_freeze_a: assert property (q.ebusy && $past(q.ebusy) |-> $stable(q.bitcnt))
      else $error("receiver moved during erase");
   chip_code_a: assert property ($rose(o_erase_busy) && $past(q.eopt) == `SFS_ER_CHIP
      |-> o_erase_mask == '1)
      else $error("chip erase mask wrong");
   block_code_a: assert property ($rose(o_erase_busy) && $past(q.eopt) == `SFS_ER_BLK1
      |-> o_erase_mask == 10'h004)
      else $error("block erase mask wrong");
   prot_clear_a: assert property ($rose(o_erase_busy) && $past(i_prot_set) == '0
      |-> (o_prot & o_erase_mask) == '0)
      else $error("protection kept after erase");
   prot_only_a: assert property ((|($past(o_prot) & ~o_prot)) |-> $rose(o_erase_busy))
      else $error("protection cleared without erase");
   bad_code_a: assert property (pop && cmd == `SFS_CMD_TW && q.mcr[`SFS_MCR_CFG]
      && q.tp == `SFS_OPT_ADDR && erase_decode(pl[7:0]) == '0 |=> !q.erase_arm)
      else $error("unknown erase code armed");
   prog_end_a: assert property ((o_prog_on || o_row_erase_on) && fall
      |=> !o_prog_on && !o_row_erase_on && o_panel_en == '0)
      else $error("operation outlived clock low");
   single_panel_a: assert property ($rose(o_prog_on) && !q.ctrl[`SFS_MULTI_BIT]
      |-> $onehot(o_panel_en))
      else $error("single panel mode enabled many");
   multi_panel_a: assert property ($rose(o_prog_on) && q.ctrl[`SFS_MULTI_BIT]
      |-> o_panel_en == `SFS_ALL_PANELS)
      else $error("multi panel not all enabled");
   tp_step_a: assert property (pop && cmd == `SFS_CMD_TWPI |=> q.tp == $past(q.tp) + 22'h2)
      else $error("pointer not advanced by two");
endmodule : sfs_seq
`default_nettype wire

// *** rtl/sfs_cfg.svh ***
// Constants of the serial erase and program sequencer.
// Assumes inclusion by bare name from any file that needs them.
`ifndef SFS_CFG_SVH
`define SFS_CFG_SVH
`define SFS_CLK_NS     10
`define SFS_P11_NS     5000000
`define SFS_P11_CYC    ((`SFS_P11_NS + `SFS_CLK_NS - 1) / `SFS_CLK_NS)
`define SFS_LAST_BIT   5'h13
`define SFS_CMD_LAST   5'h03
`define SFS_CMD_CORE   4'h0
`define SFS_CMD_TW     4'hC
`define SFS_CMD_TWPI   4'hD
`define SFS_CMD_TWSP   4'hF
`define SFS_OPT_ADDR   22'h3C0004
`define SFS_CTRL_ADDR  22'h3C0006
`define SFS_ER_CHIP    8'h80
`define SFS_ER_DATA    8'h81
`define SFS_ER_BOOT    8'h83
`define SFS_ER_BLK1    8'h88
`define SFS_ER_BLK8    8'h8F
`define SFS_BLK_BASE   4'h2
`define SFS_MULTI_BIT  6
`define SFS_MCR_CFG    6
`define SFS_MCR_FREE   4
`define SFS_OP_MOVLW   8'h0E
`define SFS_OP_MOVWF   8'h6E
`define SFS_OP_CLRF    8'h6A
`define SFS_OP_BSF     4'h8
`define SFS_OP_BCF     4'h9
`define SFS_F_MCR      8'hA6
`define SFS_F_TPU      8'hF8
`define SFS_F_TPH      8'hF7
`define SFS_F_TPL      8'hF6
`define SFS_TP_INC     22'h000002
`define SFS_ALL_PANELS 8'hFF
`endif

// *** rtl/sfs_pkg.sv ***
// Types shared by the serial erase and program sequencer.
// Assumes the constants header is on the include path.
`include "sfs_cfg.svh"
package sfs_pkg;
   // Region mask: bit 0 boot, bit 1 data memory, bits 2..9 code blocks 1..8.
   typedef logic [9:0] region_type;
   typedef logic [7:0][3:0][15:0] wbuf_type;
   typedef struct packed {
      logic [2:0]  pgc_s;
      logic [1:0]  pgd_s;
      logic [19:0] shift;
      logic [4:0]  bitcnt;
      logic        push_v;
      logic [19:0] push_w;
      logic        ovf;
      logic [7:0]  wreg;
      logic [21:0] tp;
      logic [7:0]  mcr;
      logic [7:0]  ctrl;
      logic [7:0]  eopt;
      logic        erase_arm;
      logic        prog_arm;
      logic        row_mode;
      logic        ebusy;
      logic [31:0] ecnt;
      region_type  emask;
      region_type  prot;
      logic        prog_on;
      logic        row_on;
      logic [7:0]  pen;
      logic [12:0] offset;
      wbuf_type    wbuf;
   } seq_state_type;
endpackage : sfs_pkg

// *** tb/sfs_prog_model.sv ***
// Programmer model that drives the serial clock and data pins of the sequencer.
// Assumes the caller orders the instructions; every pin change lands on falling mclk.
`timescale 1ns/1ps
`default_nettype none
module sfs_prog_model #(
   parameter int HALF = 8, // Cycles in one serial clock half period.
   parameter int P10C = 20 // Low hold after a timed window, in cycles.
) (
   input  wire logic i_mclk, // Bench clock.
   output logic      o_pgc,  // prog_serial_clock drive.
   output logic      o_pgd   // prog_serial_data drive.
);
   // The serial clock stands low outside frames.
   initial
   begin
      o_pgc = 1'b0;
      o_pgd = 1'b1;
   end
   // One bit: data changes with the rising clock and is held past the fall.
   task automatic bit1(input logic b);
      @(negedge i_mclk);
      o_pgc = 1'b1;
      o_pgd = b;
      repeat (HALF - 1) @(negedge i_mclk);
      o_pgc = 1'b0;
      repeat (HALF) @(negedge i_mclk);
   endtask : bit1
   // A whole instruction, command nibble first, least significant bit first.
   task automatic instr(input logic [3:0] cmd, input logic [15:0] pl);
      logic [19:0] w;
      w = {pl, cmd};
      for (int i = 0; i < 20; i++)
         bit1(w[i]);
      o_pgd = ~w[19]; // A released line must not look like a held value.
   endtask : instr
   // Zero bits; the data line stays low, as an erase in progress demands.
   task automatic zeros(input int n);
      for (int i = 0; i < n; i++)
         bit1(1'b0);
   endtask : zeros
   // Raise the fourth clock of a timed no-operation and leave it high.
   task automatic rise();
      @(negedge i_mclk);
      o_pgc = 1'b1;
      o_pgd = 1'b0;
   endtask : rise
   // Drop the clock to end the window, then let the array discharge.
   task automatic fall();
      @(negedge i_mclk);
      o_pgc = 1'b0;
      repeat (P10C) @(negedge i_mclk);
   endtask : fall
endmodule : sfs_prog_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the serial erase and program sequencer.
// Assumes the programmer model drives the serial pins on falling mclk.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin bad_count++; \
   $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
   import sfs_pkg::*;
   localparam int ECYC = 200; // Short erase keeps the run brief.
   localparam int P9C  = 40;  // Held-high programming time in cycles.
   logic       i_mclk      = 1'b0;
   logic       i_rst       = 1'b1;
   region_type i_prot_set  = 10'h000;
   int         bad_count   = 0;
   int         check_count = 0;
   int         busy_len    = 0;
   wire        prog_serial_clock, prog_serial_data, pgd_out, pgd_oe, erase_busy, prog_on, row_on, overflow;
   region_type erase_mask, prot;
   logic [7:0] panel_en, panel_ctrl;
   logic [12:0] offset;
   wbuf_type   wbuf;
   logic [7:0] codes [13] = '{8'h80, 8'h81, 8'h83, 8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C,
                              8'h8D, 8'h8E, 8'h8F, 8'h84, 8'h90};
   region_type masks [13] = '{10'h3FF, 10'h002, 10'h001, 10'h004, 10'h008, 10'h010,
                              10'h020, 10'h040, 10'h080, 10'h100, 10'h200, 10'h000, 10'h000};
   // Clock and a count of the cycles an erase keeps the busy level up.
   always #5 i_mclk = ~i_mclk;
   always @(negedge i_mclk)
      if (erase_busy === 1'b1)
         busy_len++;
   sfs_prog_model prog_u (.i_mclk(i_mclk), .o_pgc(prog_serial_clock), .o_pgd(prog_serial_data));
   sfs_seq #(.ERASE_CYC(ECYC)) dut_u (
      .i_mclk(i_mclk), .i_rst(i_rst), .i_pgc(prog_serial_clock), .i_pgd(prog_serial_data), .i_prot_set(i_prot_set),
      .o_pgd_out(pgd_out), .o_pgd_oe(pgd_oe), .o_erase_busy(erase_busy),
      .o_erase_mask(erase_mask), .o_prot(prot), .o_prog_on(prog_on),
      .o_row_erase_on(row_on), .o_panel_en(panel_en), .o_offset(offset), .o_wbuf(wbuf),
      .o_panel_ctrl(panel_ctrl), .o_overflow(overflow));
   // Verdict in one place.
   task automatic wrap_up();
      $display("checks %0d errors %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up
   task automatic core(input logic [15:0] pl);
      prog_u.instr(4'h0, pl);
   endtask : core
   // Table pointer load through core move instructions.
   task automatic load_tp(input logic [21:0] a);
      core({10'h038, a[21:16]});
      core(16'h6EF8);
      core({8'h0E, a[15:8]});
      core(16'h6EF7);
      core({8'h0E, a[7:0]});
      core(16'h6EF6);
   endtask : load_tp
   // Config-space table write, then back to code space.
   task automatic cfg_wr(input logic [21:0] a, input logic [7:0] v);
      core(16'h8CA6);
      load_tp(a);
      prog_u.instr(4'hC, {8'h00, v});
      core(16'h9CA6);
   endtask : cfg_wr
   // Option write plus no-operation; protection is set first so clearing shows.
   task automatic erase(input logic [7:0] code, input region_type m);
      int i;
      @(negedge i_mclk);
      i_prot_set = 10'h3FF;
      @(negedge i_mclk);
      i_prot_set = 10'h000;
      busy_len = 0;
      prog_u.instr(4'hC, {8'h00, code});
      prog_u.zeros(4);
      `CHK("busy", (m != 10'h000), erase_busy)
      `CHK("mask", m, erase_mask)
      `CHK("prot", 10'h3FF & ~m, prot)
      if (m != 10'h000)
      begin
         prog_u.zeros(4);
         for (i = 0; i < 1000 && erase_busy !== 1'b0; i++)
            @(negedge i_mclk);
         if (i == 1000)
         begin
            bad_count++;
            wrap_up();
         end
         `CHK("busy_len", ECYC, busy_len)
      end
      prog_u.zeros(16);
   endtask : erase
   // Timed no-operation whose fourth clock is held high for the window.
   task automatic pulse(input logic po, input logic ro, input logic [7:0] en,
                        input logic [12:0] off);
      prog_u.zeros(3);
      prog_u.rise();
      repeat (P9C) @(negedge i_mclk);
      `CHK("prog_on", po, prog_on)
      `CHK("row_on", ro, row_on)
      `CHK("panel_en", en, panel_en)
      `CHK("offset", off, offset)
      `CHK("prot", 10'h3FF, prot)
      prog_u.fall();
      `CHK("window_off", 1'b0, prog_on | row_on)
      `CHK("en_off", 8'h00, panel_en)
      prog_u.zeros(16);
   endtask : pulse
   // Main sequence: reset, every erase option, both write modes, row erase.
   initial
   begin
      repeat (8) @(negedge i_mclk);
      i_rst = 1'b0;
      repeat (4) @(negedge i_mclk);
      `CHK("reset_prot", 10'h000, prot)
      `CHK("reset_ctrl", 8'h00, panel_ctrl)
      `CHK("reset_busy", 1'b0, erase_busy | prog_on | pgd_oe)
      core(16'h8CA6);
      load_tp(22'h3C0004);
      for (int k = 0; k < 13; k++)
         erase(codes[k], masks[k]);
      cfg_wr(22'h3C0006, 8'h40);
      `CHK("ctrl_multi", 8'h40, panel_ctrl)
      load_tp(22'h002010);
      prog_u.instr(4'hD, 16'h1111);
      prog_u.instr(4'hD, 16'h2222);
      prog_u.instr(4'hD, 16'h3333);
      prog_u.instr(4'hC, 16'h4444);
      `CHK("wbuf_1_0", 16'h1111, wbuf[1][0])
      `CHK("wbuf_1_3", 16'h4444, wbuf[1][3])
      load_tp(22'h00E010);
      prog_u.instr(4'hD, 16'h5555);
      prog_u.instr(4'hD, 16'h6666);
      prog_u.instr(4'hD, 16'h7777);
      prog_u.instr(4'hF, 16'h8888);
      `CHK("wbuf_7_3", 16'h8888, wbuf[7][3])
      pulse(1'b1, 1'b0, 8'hFF, 13'h0010);
      cfg_wr(22'h3C0006, 8'h00);
      `CHK("ctrl_single", 8'h00, panel_ctrl)
      load_tp(22'h006008);
      prog_u.instr(4'hD, 16'hAAAA);
      prog_u.instr(4'hD, 16'hBBBB);
      prog_u.instr(4'hD, 16'hCCCC);
      prog_u.instr(4'hF, 16'hDDDD);
      `CHK("wbuf_3_0", 16'hAAAA, wbuf[3][0])
      pulse(1'b1, 1'b0, 8'h08, 13'h0008);
      cfg_wr(22'h3C0006, 8'h40);
      core(16'h6AF8);
      core(16'h6AF7);
      core(16'h6AF6);
      core(16'h88A6);
      prog_u.instr(4'hF, 16'h0000);
      pulse(1'b0, 1'b1, 8'hFF, 13'h0000);
      `CHK("overflow", 1'b0, overflow)
      `CHK("pgd_drive", 2'b00, {pgd_oe, pgd_out})
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
